// *** rtl/lepc_top.sv ***
`timescale 1ns/10ps
// Functional notes
// [R1] energy detect acts only while enabled
// [R2] software disables crossover when negotiation off
// [R3] auto wake when data count meets threshold
// [R4] auto sleep when line energy vanishes
// [R5] manual toggle starts sequence, self-clears
// [R6] manual toggle ignores counts and timers
// [R7] power-up sends burst of four pulses
// [R8] burst disable sends single pulse instead
// [R9] power state bit reads current state
// [R10] error met flag informational, clear on read
// [R11] data met flag when count reaches threshold
// [R12] error threshold field, reset one
// [R13] data threshold field, reset one
// [R14] counters clear after two quiet seconds
// [R15] separate counters compared against thresholds
`include "lepc_params.svh"
module lepc_top #(
    parameter int unsigned QUIET_CYCLES = `LEPC_QUIET_CYCLES
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire lepc_pkg::lepc_ahb_req_s ahb_req_in,
    output lepc_pkg::lepc_ahb_rsp_s      ahb_rsp_out,
    input  wire logic                    data_event_in,
    input  wire logic                    error_event_in,
    input  wire logic                    line_energy_in,
    output logic                         power_up_out,
    output logic                         pulse_out,
    output logic                         irq_out
);
    import lepc_pkg::*;

    // register select from a byte address
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr[1:0] == 2'h0) begin
            if (addr[9:2] == `LEPC_CTRL_IDX) sel = 2'h1;
            if (addr[9:2] == `LEPC_IRQ_STAT_IDX) sel = 2'h2;
            if (addr[9:2] == `LEPC_IRQ_MASK_IDX) sel = 2'h3;
            if (addr[31:10] != 22'h0) sel = 2'h0;
        end
        return sel;
    endfunction

    // three-stage pin synchronisers and filtered levels
    logic [2:0] sy1_r, sy2_r, sy3_r, flt_r, flt_nxt;
    logic       data_edge, err_edge, energy_on;

    always_comb begin
        flt_nxt = flt_r;
        for (int i = 0; i < 3; i++) begin
            if (sy2_r[i] == sy3_r[i]) flt_nxt[i] = sy3_r[i];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sy1_r <= 3'h0;
            sy2_r <= 3'h0;
            sy3_r <= 3'h0;
            flt_r <= 3'h0;
        end else begin
            sy1_r <= {line_energy_in, error_event_in, data_event_in};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            flt_r <= flt_nxt;
        end
    end

    assign data_edge = flt_nxt[0] & ~flt_r[0];
    assign err_edge  = flt_nxt[1] & ~flt_r[1];
    assign energy_on = flt_r[2];

    // bus address/data phase tracking
    logic        dph_vld_r, dph_vld_nxt, dph_wr_r, dph_wr_nxt;
    logic [1:0]  dph_sel_r, dph_sel_nxt;
    logic        rd_done_r, rd_done_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        addr_take, hready_int, rd_load, wr_do;

    assign hready_int = !(dph_vld_r && !dph_wr_r && !rd_done_r);
    assign addr_take  = ahb_req_in.hsel && ahb_req_in.htrans[1] &&
                        ahb_req_in.hready;
    assign rd_load    = dph_vld_r && !dph_wr_r && !rd_done_r;
    assign wr_do      = dph_vld_r && dph_wr_r;

    // control, flag and interrupt registers
    logic       enable_r, enable_nxt, wake_r, wake_nxt, sleep_r, sleep_nxt;
    logic       man_r, man_nxt, bdis_r, bdis_nxt;
    logic       dmet_r, dmet_nxt, emet_r, emet_nxt;
    logic [3:0] ethr_r, ethr_nxt, dthr_r, dthr_nxt;
    logic [3:0] istat_r, istat_nxt, imask_r, imask_nxt;
    logic [3:0] dcnt_r, dcnt_nxt, ecnt_r, ecnt_nxt;
    logic [24:0] quiet_r, quiet_nxt;
    lepc_pwr_e  pwr_r, pwr_nxt;
    logic [2:0] pleft_r, pleft_nxt, gap_r, gap_nxt;
    logic       pulse_r, pulse_nxt;
    logic       dmet_set, emet_set, quiet_wrap, pwr_chg;
    logic [15:0] ctrl_val;

    assign ctrl_val = {enable_r, wake_r, sleep_r, man_r, bdis_r,
                       pwr_r == PWR_UP, emet_r, dmet_r, ethr_r, dthr_r};
    assign dmet_set   = dcnt_r >= dthr_r;                      // [R11]
    assign emet_set   = ecnt_r >= ethr_r;                      // [R10]
    assign quiet_wrap = quiet_r == 25'(QUIET_CYCLES - 1);

    // bus phase next state and read data capture
    always_comb begin
        dph_vld_nxt = dph_vld_r;
        dph_wr_nxt  = dph_wr_r;
        dph_sel_nxt = dph_sel_r;
        rd_done_nxt = rd_done_r;
        hrdata_nxt  = hrdata_r;
        if (rd_load) begin
            rd_done_nxt = 1'b1;
            unique case (dph_sel_r)
                2'h1: hrdata_nxt = {16'h0, ctrl_val};          // [R9]
                2'h2: hrdata_nxt = {28'h0, istat_r};
                2'h3: hrdata_nxt = {28'h0, imask_r};
                2'h0: hrdata_nxt = 32'h0;
            endcase
        end else if (hready_int) begin
            dph_vld_nxt = addr_take;
            dph_wr_nxt  = ahb_req_in.hwrite;
            dph_sel_nxt = reg_sel(ahb_req_in.haddr);
            rd_done_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dph_vld_r <= 1'b0;
            dph_wr_r  <= 1'b0;
            dph_sel_r <= 2'h0;
            rd_done_r <= 1'b0;
            hrdata_r  <= 32'h0;
        end else begin
            dph_vld_r <= dph_vld_nxt;
            dph_wr_r  <= dph_wr_nxt;
            dph_sel_r <= dph_sel_nxt;
            rd_done_r <= rd_done_nxt;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // software-visible register updates
    always_comb begin
        enable_nxt = enable_r;
        wake_nxt   = wake_r;
        sleep_nxt  = sleep_r;
        man_nxt    = 1'b0;                                     // [R5]
        bdis_nxt   = bdis_r;
        ethr_nxt   = ethr_r;
        dthr_nxt   = dthr_r;
        imask_nxt  = imask_r;
        istat_nxt  = istat_r;
        dmet_nxt   = dmet_r;
        emet_nxt   = emet_r;
        if (wr_do && dph_sel_r == 2'h1) begin
            enable_nxt = ahb_req_in.hwdata[`LEPC_ENABLE_BIT];  // [R1]
            wake_nxt   = ahb_req_in.hwdata[`LEPC_WAKE_BIT];    // [R3]
            sleep_nxt  = ahb_req_in.hwdata[`LEPC_SLEEP_BIT];   // [R4]
            man_nxt    = ahb_req_in.hwdata[`LEPC_MANUAL_BIT];  // [R5]
            bdis_nxt   = ahb_req_in.hwdata[`LEPC_BURST_DIS_BIT];
            ethr_nxt   = ahb_req_in.hwdata[`LEPC_ERR_THR_LSB +: 4];  // [R12]
            dthr_nxt   = ahb_req_in.hwdata[`LEPC_DATA_THR_LSB +: 4]; // [R13]
        end
        if (wr_do && dph_sel_r == 2'h3) begin
            imask_nxt = ahb_req_in.hwdata[3:0];
        end
        if (wr_do && dph_sel_r == 2'h2) begin
            istat_nxt = istat_r & ~ahb_req_in.hwdata[3:0];
        end
        // clear on read, a new set wins
        if (rd_load && dph_sel_r == 2'h1) begin
            dmet_nxt = 1'b0;                                   // [R11]
            emet_nxt = 1'b0;                                   // [R10]
        end
        if (dmet_set) dmet_nxt = 1'b1;                         // [R11]
        if (emet_set) emet_nxt = 1'b1;                         // [R10]
        if (dmet_set && !dmet_r) istat_nxt[`LEPC_IRQ_DATA_BIT] = 1'b1;
        if (emet_set && !emet_r) istat_nxt[`LEPC_IRQ_ERR_BIT] = 1'b1;
        if (pwr_chg && pwr_nxt == PWR_UP) begin
            istat_nxt[`LEPC_IRQ_WAKE_BIT] = 1'b1;
        end
        if (pwr_chg && pwr_nxt == PWR_DOWN) begin
            istat_nxt[`LEPC_IRQ_SLEEP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            enable_r <= `LEPC_ENABLE_RST;
            wake_r   <= `LEPC_WAKE_RST;
            sleep_r  <= `LEPC_SLEEP_RST;
            man_r    <= 1'b0;
            bdis_r   <= `LEPC_BURST_DIS_RST;
            ethr_r   <= `LEPC_ERR_THR_RST;
            dthr_r   <= `LEPC_DATA_THR_RST;
            imask_r  <= `LEPC_IRQ_MASK_RST;
            istat_r  <= 4'h0;
            dmet_r   <= 1'b0;
            emet_r   <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            wake_r   <= wake_nxt;
            sleep_r  <= sleep_nxt;
            man_r    <= man_nxt;
            bdis_r   <= bdis_nxt;
            ethr_r   <= ethr_nxt;
            dthr_r   <= dthr_nxt;
            imask_r  <= imask_nxt;
            istat_r  <= istat_nxt;
            dmet_r   <= dmet_nxt;
            emet_r   <= emet_nxt;
        end
    end

    // power state machine; error events never move it
    always_comb begin
        pwr_nxt = pwr_r;
        if (!enable_r) begin
            pwr_nxt = PWR_UP;                                  // [R1]
        end else if (man_r) begin
            pwr_nxt = (pwr_r == PWR_UP) ? PWR_DOWN : PWR_UP;   // [R6]
        end else begin
            unique case (pwr_r)
                PWR_DOWN: if (wake_r && dmet_set) pwr_nxt = PWR_UP; // [R3]
                PWR_UP: begin
                    if (sleep_r && !energy_on) pwr_nxt = PWR_DOWN; // [R4]
                end
            endcase
        end
    end

    assign pwr_chg = enable_r && (pwr_nxt != pwr_r);

    // event counters and quiet timer
    always_comb begin
        dcnt_nxt  = dcnt_r;
        ecnt_nxt  = ecnt_r;
        quiet_nxt = quiet_r + 25'h1;
        if (data_edge && dcnt_r != 4'hf) dcnt_nxt = dcnt_r + 4'h1; // [R15]
        if (err_edge && ecnt_r != 4'hf) ecnt_nxt = ecnt_r + 4'h1;  // [R15]
        if (data_edge) begin
            quiet_nxt = 25'h0;
        end else if (quiet_wrap) begin
            quiet_nxt = 25'h0;
            dcnt_nxt  = 4'h0;                                  // [R14]
            ecnt_nxt  = 4'h0;                                  // [R14]
        end
        if (pwr_chg || !enable_r) begin
            dcnt_nxt = 4'h0;
            ecnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pwr_r   <= PWR_UP;
            dcnt_r  <= 4'h0;
            ecnt_r  <= 4'h0;
            quiet_r <= 25'h0;
        end else begin
            pwr_r   <= pwr_nxt;
            dcnt_r  <= dcnt_nxt;
            ecnt_r  <= ecnt_nxt;
            quiet_r <= quiet_nxt;
        end
    end

    // pulse burst generator on each power-up while enabled
    always_comb begin
        pleft_nxt = pleft_r;
        gap_nxt   = gap_r;
        pulse_nxt = 1'b0;
        if (gap_r != 3'h0) begin
            gap_nxt = gap_r - 3'h1;
        end else if (pleft_r != 3'h0) begin
            pulse_nxt = 1'b1;
            pleft_nxt = pleft_r - 3'h1;
            gap_nxt   = `LEPC_PULSE_GAP;
        end
        if (pwr_chg && pwr_nxt == PWR_UP) begin
            pleft_nxt = bdis_r ? `LEPC_SINGLE_PULSE            // [R8]
                               : `LEPC_BURST_PULSES;           // [R7]
            gap_nxt   = 3'h0;
        end
        if (!enable_r || pwr_nxt == PWR_DOWN) begin
            pleft_nxt = 3'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pleft_r <= 3'h0;
            gap_r   <= 3'h0;
            pulse_r <= 1'b0;
        end else begin
            pleft_r <= pleft_nxt;
            gap_r   <= gap_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // outputs
    assign ahb_rsp_out.hreadyout = hready_int;
    assign ahb_rsp_out.hresp     = 1'b0;
    assign ahb_rsp_out.hrdata    = hrdata_r;
    assign power_up_out          = pwr_r == PWR_UP;
    assign pulse_out             = pulse_r;
    assign irq_out               = |(istat_r & imask_r);

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_disabled_up: assert property (!enable_r |=> power_up_out) // [R1]
        else $error("state moved while detection disabled");
    a_auto_wake: assert property (enable_r && !man_r && wake_r && // [R3]
        pwr_r == PWR_DOWN && dmet_set |=> power_up_out)
        else $error("no wake at data threshold");
    a_auto_sleep: assert property (enable_r && !man_r && sleep_r && // [R4]
        pwr_r == PWR_UP && !energy_on |=> !power_up_out)
        else $error("no sleep without energy");
    a_man_self_clear: assert property (man_r |=> !man_r) // [R5]
        else $error("manual toggle did not clear");
    a_man_toggle: assert property (enable_r && man_r |=> // [R6]
        power_up_out != $past(power_up_out))
        else $error("manual toggle ignored");
    a_burst_load: assert property ($rose(power_up_out) && enable_r |-> // [R7]
        pleft_r == ($past(bdis_r) ? 3'h1 : 3'h4))
        else $error("wrong pulse count at power up");
    a_pulse_gap: assert property (pulse_out |=> !pulse_out [*5]) // [R8]
        else $error("pulses too close");
    a_state_read: assert property (rd_load && dph_sel_r == 2'h1 |=> // [R9]
        hrdata_r[10] == $past(power_up_out))
        else $error("power state bit wrong");
    a_err_flag: assert property (emet_set |=> emet_r) // [R10]
        else $error("error flag not set");
    a_cor_clear: assert property (rd_load && dph_sel_r == 2'h1 && // [R11]
        !dmet_set |=> !dmet_r)
        else $error("data flag not cleared by read");
    a_thr_write: assert property (wr_do && dph_sel_r == 2'h1 |=> // [R12]
        ethr_r == $past(ahb_req_in.hwdata[7:4]) &&
        dthr_r == $past(ahb_req_in.hwdata[3:0])) // [R13]
        else $error("threshold write lost");
    a_quiet_reset: assert property (quiet_wrap && !data_edge |=> // [R14]
        dcnt_r == 4'h0 && ecnt_r == 4'h0)
        else $error("counters survived quiet period");
    a_count_inc: assert property (data_edge && dcnt_r != 4'hf && // [R15]
        !pwr_chg && enable_r |=> dcnt_r == $past(dcnt_r) + 4'h1)
        else $error("data count not advanced");

    c_wake: cover property (enable_r && $rose(power_up_out));
    c_sleep: cover property (enable_r && $fell(power_up_out));
    c_burst: cover property (pulse_out ##6 pulse_out ##6 pulse_out);
    c_irq: cover property ($rose(irq_out));
endmodule

// *** shared/lepc_params.svh ***
`ifndef LEPC_PARAMS_SVH
`define LEPC_PARAMS_SVH

// register indices; byte address is four times the index
`define LEPC_CTRL_IDX        8'h1d
`define LEPC_IRQ_STAT_IDX    8'h1e
`define LEPC_IRQ_MASK_IDX    8'h1f

// control register field positions
`define LEPC_ENABLE_BIT      15
`define LEPC_WAKE_BIT        14
`define LEPC_SLEEP_BIT       13
`define LEPC_MANUAL_BIT      12
`define LEPC_BURST_DIS_BIT   11
`define LEPC_PWR_STATE_BIT   10
`define LEPC_ERR_MET_BIT     9
`define LEPC_DATA_MET_BIT    8
`define LEPC_ERR_THR_LSB     4
`define LEPC_DATA_THR_LSB    0

// control and interrupt mask register reset values
`define LEPC_ENABLE_RST      1'b0
`define LEPC_WAKE_RST        1'b1
`define LEPC_SLEEP_RST       1'b1
`define LEPC_BURST_DIS_RST   1'b0
`define LEPC_ERR_THR_RST     4'h1
`define LEPC_DATA_THR_RST    4'h1
`define LEPC_IRQ_MASK_RST    4'h0

// interrupt status bit positions
`define LEPC_IRQ_DATA_BIT    0
`define LEPC_IRQ_ERR_BIT     1
`define LEPC_IRQ_WAKE_BIT    2
`define LEPC_IRQ_SLEEP_BIT   3

// timing
`define LEPC_CLK_HZ          10000000
`define LEPC_QUIET_TIME_MS   2000
`define LEPC_QUIET_CYCLES    (`LEPC_QUIET_TIME_MS * (`LEPC_CLK_HZ / 1000))
`define LEPC_BURST_PULSES    3'h4
`define LEPC_SINGLE_PULSE    3'h1
`define LEPC_PULSE_GAP       3'h5

`endif

// *** shared/lepc_pkg.sv ***
package lepc_pkg;

    typedef enum logic {
        PWR_DOWN = 1'b0,
        PWR_UP   = 1'b1
    } lepc_pwr_e;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } lepc_ahb_req_s;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } lepc_ahb_rsp_s;

endpackage

// *** tb/lepc_link_partner.sv ***
`timescale 1ns/10ps
// far end of the cable: raises line events, counts detect pulses
module lepc_link_partner (
    input  wire logic clk_in,
    input  wire logic pulse_in,
    output logic      data_event_out,
    output logic      error_event_out,
    output logic      line_energy_out
);
    int pulses_seen = 0;
    // quiet line with energy present
    initial begin
        data_event_out = 1'b0;
        error_event_out = 1'b0;
        line_energy_out = 1'b1;
    end
    // tally of detect pulses seen on the wire
    always @(posedge clk_in) begin
        if (pulse_in === 1'b1) begin
            pulses_seen <= pulses_seen + 1;
        end
    end
    // events held high two cycles, low three, so the filter sees each
    task automatic send(input bit err, input int n);
        repeat (n) begin
            @(posedge clk_in);
            error_event_out <= err;
            data_event_out <= !err;
            repeat (2) @(posedge clk_in);
            error_event_out <= 1'b0;
            data_event_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask
    // energy level changes just after an edge
    task automatic set_energy(input logic v);
        @(posedge clk_in);
        line_energy_out <= v;
    endtask
endmodule

// *** tb/test_line_energy_power_control.sv ***
`timescale 1ns/10ps
`include "lepc_params.svh"
module test_line_energy_power_control;
    import lepc_pkg::*;
    localparam logic [31:0] CTRL_A = {22'h0, `LEPC_CTRL_IDX, 2'b00};
    localparam logic [31:0] STAT_A = {22'h0, `LEPC_IRQ_STAT_IDX, 2'b00};
    localparam logic [31:0] MASK_A = {22'h0, `LEPC_IRQ_MASK_IDX, 2'b00};
    localparam int          QUIET  = 50;
    logic          clk_in          = 1'b0;
    logic          rst_n_in        = 1'b0;
    logic          m_sel           = 1'b0;
    logic [31:0]   m_addr          = 32'h0;
    logic [1:0]    m_trans         = 2'h0;
    logic          m_write         = 1'b0;
    logic [31:0]   m_wdata         = 32'h0;
    logic [31:0]   last_rdata;
    logic [31:0]   rd;
    lepc_ahb_req_s ahb_req;
    lepc_ahb_rsp_s ahb_rsp;
    logic          data_ev;
    logic          err_ev;
    logic          energy;
    logic          power_up;
    logic          pulse;
    logic          irq;
    int            n_mismatch      = 0;
    int            samples_checked = 0;
    int            cycles          = 0;
    int            p0;

    // bus request; hready follows the only slave
    assign ahb_req = {m_sel, m_addr, m_trans, m_write, 3'h2,
                      ahb_rsp.hreadyout, m_wdata};

    lepc_top #(.QUIET_CYCLES(QUIET)) dut (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .ahb_req_in    (ahb_req),
        .ahb_rsp_out   (ahb_rsp),
        .data_event_in (data_ev),
        .error_event_in(err_ev),
        .line_energy_in(energy),
        .power_up_out  (power_up),
        .pulse_out     (pulse),
        .irq_out       (irq)
    );

    lepc_link_partner lp (
        .clk_in         (clk_in),
        .pulse_in       (pulse),
        .data_event_out (data_ev),
        .error_event_out(err_ev),
        .line_energy_out(energy)
    );

    // 10 MHz clock
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            $display("[ERR] t=%0t timeout", $time);
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ends on a falling edge so outputs are settled
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    // hold until hready is seen high at a rising edge
    task automatic wait_ready;
        logic r;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge clk_in);
            r = ahb_rsp.hreadyout;
            last_rdata = ahb_rsp.hrdata;
            @(posedge clk_in);
        end
    endtask

    task automatic ahb_xfer(input logic w, input logic [31:0] a,
                            input logic [31:0] d);
        @(posedge clk_in);
        m_sel <= 1'b1;
        m_addr <= a;
        m_trans <= 2'b10;
        m_write <= w;
        wait_ready();
        m_sel <= 1'b0;
        m_trans <= 2'b00;
        m_wdata <= d;
        wait_ready();
    endtask

    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d);
    endtask

    // masked register read compared with an expectation
    task automatic rchk(input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        ahb_xfer(1'b0, a, 32'h0);
        rd = last_rdata;
        chk(rd & m, e);
    endtask

    // reset values, unmapped place, disabled block ignores everything
    task automatic test_reset;
        rchk(CTRL_A, 32'hffff_fbff, 32'h0000_6011);
        chk({31'h0, ahb_rsp.hresp}, 32'h0);
        rchk(STAT_A, 32'hffff_ffff, 32'h0);
        rchk(MASK_A, 32'hffff_ffff, 32'h0);
        ahb_write(32'h40, 32'hffff_ffff);
        rchk(32'h40, 32'hffff_ffff, 32'h0);
        ahb_write(CTRL_A, 32'h7011);
        lp.send(1'b0, 2);
        wait_clk(10);
        chk({31'h0, power_up}, 32'h1);
        chk(lp.pulses_seen, 0);
        rchk(CTRL_A, 32'hffff_fbff, 32'h0000_6011);
    endtask

    // sleep on lost energy, wake on data with a burst, interrupt path;
    // crossover sits outside, nothing on the bench drives it
    task automatic test_wake;
        ahb_write(CTRL_A, 32'he011);
        lp.set_energy(1'b0);
        wait_clk(20);
        chk({31'h0, power_up}, 32'h0);
        rchk(CTRL_A, 32'h400, 32'h0);
        p0 = lp.pulses_seen;
        lp.set_energy(1'b1);
        lp.send(1'b0, 1);
        wait_clk(50);
        chk({31'h0, power_up}, 32'h1);
        chk(lp.pulses_seen - p0, 4);
        rchk(CTRL_A, 32'h400, 32'h400);
        rchk(STAT_A, 32'hf, 32'hd);
        chk({31'h0, irq}, 32'h0);
        ahb_write(MASK_A, 32'h4);
        wait_clk(2);
        chk({31'h0, irq}, 32'h1);
        ahb_write(STAT_A, 32'h4);
        wait_clk(2);
        chk({31'h0, irq}, 32'h0);
        rchk(STAT_A, 32'h4, 32'h0);
        ahb_write(STAT_A, 32'hf);
        ahb_write(MASK_A, 32'h0);
    endtask

    // manual toggles both ways, single pulse when bursts are off
    task automatic test_manual;
        ahb_write(CTRL_A, 32'h9811);
        wait_clk(5);
        chk({31'h0, power_up}, 32'h0);
        rchk(CTRL_A, 32'h1400, 32'h0);
        p0 = lp.pulses_seen;
        ahb_write(CTRL_A, 32'h9811);
        wait_clk(20);
        chk({31'h0, power_up}, 32'h1);
        chk(lp.pulses_seen - p0, 1);
    endtask

    // data threshold of three, sticky flag, quiet-time reset
    task automatic test_data;
        ahb_write(CTRL_A, 32'h80f3);
        wait_clk(QUIET + 10);
        rchk(CTRL_A, 32'h300, 32'h0);
        lp.send(1'b0, 2);
        wait_clk(6);
        rchk(CTRL_A, 32'h100, 32'h0);
        lp.send(1'b0, 1);
        wait_clk(6);
        rchk(CTRL_A, 32'h100, 32'h100);
        rchk(STAT_A, 32'h1, 32'h1);
        wait_clk(QUIET + 10);
        // count still met at the last read, so the flag stays until now
        rchk(CTRL_A, 32'h100, 32'h100);
        lp.send(1'b0, 2);
        wait_clk(6);
        rchk(CTRL_A, 32'h100, 32'h0);
    endtask

    // error threshold of two only flags, never wakes
    task automatic test_error;
        ahb_write(CTRL_A, 32'hd02f);
        wait_clk(QUIET + 10);
        rchk(CTRL_A, 32'h1700, 32'h0);
        lp.send(1'b0, 1);
        lp.send(1'b1, 1);
        wait_clk(6);
        rchk(CTRL_A, 32'h200, 32'h0);
        lp.send(1'b1, 1);
        wait_clk(6);
        rchk(CTRL_A, 32'h600, 32'h200);
        chk({31'h0, power_up}, 32'h0);
        rchk(STAT_A, 32'h2, 32'h2);
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_clk(2);
        test_reset();
        test_wake();
        test_manual();
        test_data();
        test_error();
        give_verdict();
    end
endmodule
